/* File: rtl/wic_watchdog_idle.sv */
// Purpose: Watchdog timer, halt mode entry and wake-up control
// Assumes: Core pulses halt and clear-watchdog one cycle each; inputs are
//          synchronous to clk_sys
// Notes:   Low-speed RC clock is modelled as an enable from a divider
//
// Functional notes
// - Halt with fast keep 0, sub keep 1: fast clock off, sub on, halted.
// - Halt with both keep bits 1: both clocks stay on, program halted.
// - Halt with fast keep 1, sub keep 0: fast on, sub off, halted.
// - Halt entry keeps state, sets power-down flag, clears time-out flag.
// - Halt clears watchdog counter; counts on only when watchdog enabled.
// - Halted device wakes on enabled pin fall, interrupt, or overflow.
// - Power-down flag cleared only by power-up or clear-watchdog.
// - Time-out while halted sets flag, resets only program counter, stack.
// - Pin wake resumes at the instruction after the halt.
// - Masked or stack-full interrupt wake resumes after halt; else serviced.
// - Interrupt already pending at halt entry cannot wake the device.
// - Watchdog counts low-speed RC ticks, independent of system clock.
// - Period field selects 2 to the power 8 plus field ticks.
// - Key 10101B disables the watchdog, 01010B enables it.
// - Other key values reset the device after a delay, set key flag.
// - After power-on key is 01010B and period field is 011.
// - Key flag set by illegal-key reset; cleared only by power-up or software.
// - Overflow while running gives full device reset and sets time-out.
// - Counter cleared by illegal key, clear-watchdog or halt.

`timescale 1ns/10ps

module wic_watchdog_idle #(
  parameter int unsigned KEY_RESET_DELAY = wic_pkg::KEY_DELAY_DEF,
  parameter int unsigned LOW_SPEED_RC_OSC_DIV        = wic_pkg::LOW_SPEED_RC_OSC_DIV_CYCLES
) (
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic [wic_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic [wic_pkg::REG_DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [wic_pkg::REG_DATA_W-1:0] reg_rdata,
  input  wire logic                          halt_exec,
  input  wire logic                          clear_watchdog_instr,
  input  wire logic [wic_pkg::PORTA_W-1:0]   porta_pins,
  input  wire logic [wic_pkg::IRQ_W-1:0]     irq_req,
  input  wire logic [wic_pkg::IRQ_W-1:0]     irq_enable,
  input  wire logic                          stack_full,
  input  wire logic                          low_volt_event,
  output logic                               cpu_halted,
  output logic                               high_clk_on,
  output logic                               sub_clk_on,
  output logic                               resume_next,
  output logic                               irq_service,
  output logic                               pc_sp_reset,
  output logic                               device_reset,
  output wic_pkg::wic_status_s               status_flags
);
  import wic_pkg::*;

  // ==========================================================================
  // State
  wic_mode_e                  mode;
  wic_mode_e                  next_mode;
  wic_wdt_ctrl_s              watchdog_control;
  wic_wdt_ctrl_s              next_watchdog_control;
  wic_rst_flags_s             reset_cause_flags;
  wic_rst_flags_s             next_reset_cause_flags;
  wic_clk_ctrl_s              sys_clock_ctrl;
  wic_clk_ctrl_s              next_sys_clock_ctrl;
  wic_status_s                next_status_flags;
  logic [PORTA_W-1:0]         porta_wake_enable;
  logic [PORTA_W-1:0]         next_porta_wake_enable;
  logic [PORTA_W-1:0]         porta_prev;
  logic [IRQ_W-1:0]           irq_block;
  logic [IRQ_W-1:0]           next_irq_block;
  logic [LOW_SPEED_RC_OSC_DIV_W-1:0]      low_speed_rc_osc_div;
  logic [LOW_SPEED_RC_OSC_DIV_W-1:0]      next_low_speed_rc_osc_div;
  logic [WDT_CNT_W-1:0]       wdt_cnt;
  logic [WDT_CNT_W-1:0]       next_wdt_cnt;
  logic [KEY_DELAY_W-1:0]     key_wait;
  logic [KEY_DELAY_W-1:0]     next_key_wait;
  logic [REG_DATA_W-1:0]      next_reg_rdata;
  logic                       next_cpu_halted;
  logic                       next_high_clk_on;
  logic                       next_sub_clk_on;
  logic                       next_resume_next;
  logic                       next_irq_service;
  logic                       next_pc_sp_reset;
  logic                       next_device_reset;

  logic                       low_speed_rc_osc_tick;
  logic                       wdt_enabled;
  logic                       wdt_overflow;
  logic [WDT_CNT_W-1:0]       wdt_limit;
  logic                       pin_wake;
  logic [IRQ_W-1:0]           irq_fresh;
  logic                       key_illegal;
  logic                       ctrl_wr;
  logic                       key_fire;

  // ==========================================================================
  // Low-speed tick and watchdog counter
  always_comb begin
    // Divider runs free of the system clock selection
    low_speed_rc_osc_tick = (low_speed_rc_osc_div == LOW_SPEED_RC_OSC_DIV_W'(LOW_SPEED_RC_OSC_DIV - 1));
    next_low_speed_rc_osc_div = low_speed_rc_osc_tick ? '0 : low_speed_rc_osc_div + 1'b1;
    // Limit is 2^(8+sel)-1 ticks
    wdt_limit = WDT_MAX_LIMIT >>
                (WDT_PERIOD_TOP - watchdog_control.wdt_period_select);
    // Key decode
    wdt_enabled = (watchdog_control.wdt_key_field == KEY_ENABLE) &&
                  (key_wait == '0);
    wdt_overflow = wdt_enabled && low_speed_rc_osc_tick && (wdt_cnt == wdt_limit);
    ctrl_wr = reg_wr && (reg_addr == OFS_WDT_CTRL);
    key_illegal = ctrl_wr &&
                  (reg_wdata[7:3] != KEY_ENABLE) &&
                  (reg_wdata[7:3] != KEY_DISABLE);
    key_fire = (key_wait == KEY_DELAY_W'(1));
    next_wdt_cnt = wdt_cnt;
    if (key_illegal || clear_watchdog_instr ||
        (halt_exec && mode == WIC_RUN)) begin
      next_wdt_cnt = '0;
    end else if (wdt_overflow) begin
      next_wdt_cnt = '0;
    end else if (wdt_enabled && low_speed_rc_osc_tick) begin
      next_wdt_cnt = wdt_cnt + 1'b1;
    end
    // Illegal key arms the delayed reset
    next_key_wait = key_wait;
    if (key_illegal) begin
      next_key_wait = KEY_DELAY_W'(KEY_RESET_DELAY);
    end else if (key_wait != '0) begin
      next_key_wait = key_wait - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      low_speed_rc_osc_div <= '0;
      wdt_cnt  <= '0;
      key_wait <= '0;
    end else begin
      low_speed_rc_osc_div <= next_low_speed_rc_osc_div;
      wdt_cnt  <= next_wdt_cnt;
      key_wait <= next_key_wait;
    end
  end

  // ==========================================================================
  // Mode, flags, wake and registers
  always_comb begin
    next_mode              = mode;
    next_watchdog_control  = watchdog_control;
    next_reset_cause_flags = reset_cause_flags;
    next_sys_clock_ctrl    = sys_clock_ctrl;
    next_porta_wake_enable = porta_wake_enable;
    next_status_flags      = status_flags;
    next_irq_block         = irq_block;
    next_resume_next       = 1'b0;
    next_irq_service       = 1'b0;
    next_pc_sp_reset       = 1'b0;
    next_device_reset      = 1'b0;
    next_reg_rdata         = '0;
    pin_wake  = |(porta_prev & ~porta_pins & porta_wake_enable);
    irq_fresh = irq_req & ~irq_block;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_WDT_CTRL: next_watchdog_control = wic_wdt_ctrl_s'(reg_wdata);
        OFS_RST_FLAGS: begin
          // Software clears the cause flags
          next_reset_cause_flags.low_volt_reset_flag =
            reg_wdata[BIT_LVR_FLAG];
          next_reset_cause_flags.key_reset_flag = reg_wdata[BIT_KEY_FLAG];
        end
        OFS_CLK_CTRL: begin
          next_sys_clock_ctrl.high_osc_halt_keep = reg_wdata[BIT_HIGH_KEEP];
          next_sys_clock_ctrl.low_osc_halt_keep  = reg_wdata[BIT_LOW_KEEP];
        end
        OFS_WAKE_EN: next_porta_wake_enable = reg_wdata;
        default: begin
        end
      endcase
    end

    // Register reads, one cycle later
    if (reg_rd) begin
      case (reg_addr)
        OFS_WDT_CTRL:  next_reg_rdata = watchdog_control;
        OFS_RST_FLAGS: begin
          next_reg_rdata[BIT_LVR_FLAG] =
            reset_cause_flags.low_volt_reset_flag;
          next_reg_rdata[BIT_KEY_FLAG] = reset_cause_flags.key_reset_flag;
        end
        OFS_CLK_CTRL: begin
          next_reg_rdata[BIT_HIGH_KEEP] = sys_clock_ctrl.high_osc_halt_keep;
          next_reg_rdata[BIT_LOW_KEEP]  = sys_clock_ctrl.low_osc_halt_keep;
        end
        OFS_STATUS: begin
          next_reg_rdata[BIT_TIMEOUT]    = status_flags.wdt_timeout_flag;
          next_reg_rdata[BIT_POWER_DOWN] = status_flags.power_down_flag;
        end
        OFS_WAKE_EN: next_reg_rdata = porta_wake_enable;
        default:     next_reg_rdata = '0;
      endcase
    end

    // Clear-watchdog drops the power-down flag
    if (clear_watchdog_instr) begin
      next_status_flags.power_down_flag = 1'b0;
    end

    case (mode)
      WIC_RUN: begin
        if (wdt_overflow) begin
          // Full reset, control back to its power-on value
          next_device_reset = 1'b1;
          next_status_flags.wdt_timeout_flag = 1'b1;
          next_watchdog_control = wic_wdt_ctrl_s'(WDT_CTRL_RESET);
        end else if (halt_exec) begin
          // Flags on halt entry; pending interrupts blocked, mode chosen from keep bits
          next_status_flags.power_down_flag  = 1'b1;
          next_status_flags.wdt_timeout_flag = 1'b0;
          next_irq_block = irq_req;
          case ({sys_clock_ctrl.high_osc_halt_keep,
                 sys_clock_ctrl.low_osc_halt_keep})
            2'b01:   next_mode = WIC_IDLE_SUB_CLOCK_ONLY;
            2'b11:   next_mode = WIC_IDLE_BOTH_CLOCKS;
            2'b10:   next_mode = WIC_IDLE_FAST_CLOCK_ONLY;
            default: next_mode = WIC_SLEEP;
          endcase
        end
      end
      WIC_SLEEP, WIC_IDLE_SUB_CLOCK_ONLY, WIC_IDLE_BOTH_CLOCKS,
      WIC_IDLE_FAST_CLOCK_ONLY: begin
        // Wake sources, overflow first
        if (wdt_overflow) begin
          next_status_flags.wdt_timeout_flag = 1'b1;
          next_pc_sp_reset = 1'b1;
          next_mode = WIC_RUN;
        end else if (pin_wake) begin
          next_resume_next = 1'b1;
          next_mode = WIC_RUN;
        end else if (|irq_fresh) begin
          // Serviced only when enabled and stack has room
          if ((|(irq_fresh & irq_enable)) && !stack_full) begin
            next_irq_service = 1'b1;
          end else begin
            next_resume_next = 1'b1;
          end
          next_mode = WIC_RUN;
        end
      end
      default: next_mode = WIC_RUN;
    endcase

    // Illegal-key reset fires after its delay
    if (key_fire) begin
      next_device_reset = 1'b1;
      next_watchdog_control = wic_wdt_ctrl_s'(WDT_CTRL_RESET);
    end
    // Hardware set wins over a software clear
    if (key_fire) begin
      next_reset_cause_flags.key_reset_flag = 1'b1;
    end
    if (low_volt_event) begin
      next_reset_cause_flags.low_volt_reset_flag = 1'b1;
    end

    next_cpu_halted  = (next_mode != WIC_RUN);
    next_high_clk_on = (next_mode == WIC_RUN) ||
                       (next_mode == WIC_IDLE_BOTH_CLOCKS) ||
                       (next_mode == WIC_IDLE_FAST_CLOCK_ONLY);
    next_sub_clk_on  = (next_mode == WIC_RUN) ||
                       (next_mode == WIC_IDLE_SUB_CLOCK_ONLY) ||
                       (next_mode == WIC_IDLE_BOTH_CLOCKS);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode              <= WIC_RUN;
      watchdog_control  <= wic_wdt_ctrl_s'(WDT_CTRL_RESET);
      reset_cause_flags <= '0;
      sys_clock_ctrl    <= '0;
      porta_wake_enable <= '0;
      status_flags      <= '0;
      porta_prev        <= '1;
      irq_block         <= '0;
      reg_rdata         <= '0;
      cpu_halted        <= 1'b0;
      high_clk_on       <= 1'b1;
      sub_clk_on        <= 1'b1;
      resume_next       <= 1'b0;
      irq_service       <= 1'b0;
      pc_sp_reset       <= 1'b0;
      device_reset      <= 1'b0;
    end else begin
      mode              <= next_mode;
      watchdog_control  <= next_watchdog_control;
      reset_cause_flags <= next_reset_cause_flags;
      sys_clock_ctrl    <= next_sys_clock_ctrl;
      porta_wake_enable <= next_porta_wake_enable;
      status_flags      <= next_status_flags;
      porta_prev        <= porta_pins;
      irq_block         <= next_irq_block;
      reg_rdata         <= next_reg_rdata;
      cpu_halted        <= next_cpu_halted;
      high_clk_on       <= next_high_clk_on;
      sub_clk_on        <= next_sub_clk_on;
      resume_next       <= next_resume_next;
      irq_service       <= next_irq_service;
      pc_sp_reset       <= next_pc_sp_reset;
      device_reset      <= next_device_reset;
    end
  end

endmodule

/* File: rtl/wic_pkg.sv */
// Purpose: Shared constants and types of the watchdog and idle wake control
// Assumes: Single system clock at 125 MHz, byte-wide register port
// Notes:   Offsets are register indexes on the plain register port

package wic_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned LOW_SPEED_RC_OSC_PERIOD_NS  = 31250;
  localparam int unsigned LOW_SPEED_RC_OSC_DIV_CYCLES = LOW_SPEED_RC_OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned LOW_SPEED_RC_OSC_DIV_W      = 12;
  localparam int unsigned KEY_DELAY_DEF   = 16;
  localparam int unsigned KEY_DELAY_W     = 16;

  // ==========================================================================
  // Register map
  localparam int unsigned REG_ADDR_W      = 3;
  localparam int unsigned REG_DATA_W      = 8;
  localparam logic [2:0]  OFS_WDT_CTRL    = 3'h0;
  localparam logic [2:0]  OFS_RST_FLAGS   = 3'h1;
  localparam logic [2:0]  OFS_CLK_CTRL    = 3'h2;
  localparam logic [2:0]  OFS_STATUS      = 3'h3;
  localparam logic [2:0]  OFS_WAKE_EN     = 3'h4;

  // ==========================================================================
  // Field positions and values
  localparam int unsigned BIT_LVR_FLAG    = 2;
  localparam int unsigned BIT_KEY_FLAG    = 0;
  localparam int unsigned BIT_HIGH_KEEP   = 1;
  localparam int unsigned BIT_LOW_KEEP    = 0;
  localparam int unsigned BIT_TIMEOUT     = 1;
  localparam int unsigned BIT_POWER_DOWN  = 0;
  localparam logic [4:0]  KEY_DISABLE     = 5'h15;
  localparam logic [4:0]  KEY_ENABLE      = 5'h0A;
  localparam logic [7:0]  WDT_CTRL_RESET  = 8'h53;
  localparam logic [15:0] WDT_MAX_LIMIT   = 16'h7FFF;
  localparam logic [2:0]  WDT_PERIOD_TOP  = 3'h7;
  localparam int unsigned WDT_CNT_W       = 16;
  localparam int unsigned PORTA_W         = 8;
  localparam int unsigned IRQ_W           = 8;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [4:0] wdt_key_field;
    logic [2:0] wdt_period_select;
  } wic_wdt_ctrl_s;

  typedef struct packed {
    logic wdt_timeout_flag;
    logic power_down_flag;
  } wic_status_s;

  typedef struct packed {
    logic low_volt_reset_flag;
    logic key_reset_flag;
  } wic_rst_flags_s;

  typedef struct packed {
    logic high_osc_halt_keep;
    logic low_osc_halt_keep;
  } wic_clk_ctrl_s;

  typedef enum logic [2:0] {
    WIC_RUN,
    WIC_SLEEP,
    WIC_IDLE_SUB_CLOCK_ONLY,
    WIC_IDLE_BOTH_CLOCKS,
    WIC_IDLE_FAST_CLOCK_ONLY
  } wic_mode_e;

endpackage

/* File: tb/wic_watchdog_idle_chk.sv */
// Purpose: Port-level checks of the watchdog and idle wake control
// Assumes: Sees only the ports of the top module
// Notes:   Bound into every instance of the top module
`timescale 1ns/10ps

module wic_watchdog_idle_chk #(
  parameter int unsigned KEY_RESET_DELAY = wic_pkg::KEY_DELAY_DEF
) (
  input wire logic                            clk_sys,
  input wire logic                            reset_n,
  input wire logic [wic_pkg::REG_ADDR_W-1:0]  reg_addr,
  input wire logic [wic_pkg::REG_DATA_W-1:0]  reg_wdata,
  input wire logic                            reg_wr,
  input wire logic                            halt_exec,
  input wire logic                            clear_watchdog_instr,
  input wire logic                            cpu_halted,
  input wire logic                            high_clk_on,
  input wire logic                            sub_clk_on,
  input wire logic                            resume_next,
  input wire logic                            irq_service,
  input wire logic                            pc_sp_reset,
  input wire logic                            device_reset,
  input wire wic_pkg::wic_status_s            status_flags
);
  import wic_pkg::*;
  // ==========================================================================
  // Illegal key write to reset delay counter
  logic [15:0] key_wait;
  logic [15:0] next_key_wait;
  logic        bad_key_wr;
  assign bad_key_wr = reg_wr && reg_addr == OFS_WDT_CTRL &&
    reg_wdata[7:3] != KEY_ENABLE && reg_wdata[7:3] != KEY_DISABLE;
  always_comb begin
    next_key_wait = key_wait;
    if (bad_key_wr) next_key_wait = 16'(KEY_RESET_DELAY);
    else if (key_wait != 16'h0000) next_key_wait = key_wait - 16'h0001;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) key_wait <= 16'h0000;
    else key_wait <= next_key_wait;
  end
  // ==========================================================================
  // Assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_halt_entry: assert property (
    halt_exec && !cpu_halted |=> cpu_halted || device_reset)
    else $error("halt not taken in run mode");
  a_halt_flags: assert property (
    $rose(cpu_halted) |-> status_flags.power_down_flag &&
      !status_flags.wdt_timeout_flag)
    else $error("flags wrong at halt entry");
  a_run_clocks: assert property (
    !cpu_halted |-> high_clk_on && sub_clk_on)
    else $error("clock stopped while running");
  a_pd_only_clear: assert property (
    $fell(status_flags.power_down_flag) |-> $past(clear_watchdog_instr))
    else $error("power-down flag cleared without cause");
  a_pd_by_clear: assert property (
    clear_watchdog_instr |=> !status_flags.power_down_flag)
    else $error("clear-watchdog left power-down flag set");
  a_wake_one: assert property (
    $fell(cpu_halted) |-> $onehot({resume_next, irq_service, pc_sp_reset}))
    else $error("wake without exactly one response");
  a_wake_cause: assert property (
    resume_next || irq_service || pc_sp_reset |-> $fell(cpu_halted))
    else $error("wake response outside a wake");
  a_halted_timeout: assert property (
    pc_sp_reset |-> status_flags.wdt_timeout_flag && !device_reset)
    else $error("halted time-out response wrong");
  a_key_delay: assert property (
    key_wait == 16'h0001 |=> device_reset)
    else $error("illegal key reset not at its delay");
endmodule

bind wic_watchdog_idle wic_watchdog_idle_chk #(
  .KEY_RESET_DELAY(KEY_RESET_DELAY)
) wic_watchdog_idle_chk_i (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
  .reg_wr, .halt_exec, .clear_watchdog_instr, .cpu_halted, .high_clk_on,
  .sub_clk_on, .resume_next, .irq_service, .pc_sp_reset, .device_reset,
  .status_flags);

/* File: tb/wic_core_model.sv */
// Purpose: Processor core model issuing halt and clear-watchdog
// Assumes: The bench calls its tasks; each instruction lasts one cycle
// Notes:   Signals change only by non-blocking assignment at rising edges
`timescale 1ns/10ps

module wic_core_model (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic cpu_halted,
  output logic      halt_exec,
  output logic      clear_watchdog_instr
);
  import wic_pkg::*;
  initial begin
    halt_exec = 1'b0;
    clear_watchdog_instr = 1'b0;
  end
  // A halted core executes nothing, so halt is only sent while running
  task automatic exec_halt();
    @(posedge clk_sys);
    if (!cpu_halted && reset_n) halt_exec <= 1'b1;
    @(posedge clk_sys);
    halt_exec <= 1'b0;
  endtask
  task automatic exec_clear();
    @(posedge clk_sys);
    clear_watchdog_instr <= 1'b1;
    @(posedge clk_sys);
    clear_watchdog_instr <= 1'b0;
  endtask
endmodule

/* File: tb/wic_watchdog_idle_tb.sv */
// Purpose: Self-checking bench of the watchdog and idle wake control
// Assumes: Short illegal-key reset delay; fast low-speed tick for overflows
// Notes:   Register port and core instructions are driven through tasks
`timescale 1ns/10ps

module wic_watchdog_idle_tb;
  import wic_pkg::*;
  localparam int unsigned KDLY = 2;
  localparam int unsigned LDIV = 2;
  logic              clk_sys, reset_n, reg_wr, reg_rd, stack_full;
  logic              halt_exec, clear_watchdog_instr, low_volt_event;
  logic              cpu_halted, high_clk_on, sub_clk_on;
  logic              resume_next, irq_service, pc_sp_reset, device_reset;
  logic [2:0]        reg_addr;
  logic [7:0]        reg_wdata, reg_rdata, porta_pins, irq_req, irq_enable;
  logic [3:0]        pulses;
  wic_status_s       status_flags;
  int                err_count, samples_checked, cycles;
  assign pulses = {device_reset, pc_sp_reset, irq_service, resume_next};

  wic_watchdog_idle #(
    .KEY_RESET_DELAY(KDLY),
    .LOW_SPEED_RC_OSC_DIV       (LDIV)
  ) wic_watchdog_idle_i (
    .clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .halt_exec, .clear_watchdog_instr, .porta_pins, .irq_req, .irq_enable,
    .stack_full, .low_volt_event, .cpu_halted, .high_clk_on, .sub_clk_on,
    .resume_next, .irq_service, .pc_sp_reset, .device_reset, .status_flags);
  wic_core_model wic_core_model_i (.clk_sys, .reset_n, .cpu_halted,
    .halt_exec, .clear_watchdog_instr);

  // ==========================================================================
  // Tasks
  task automatic check(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_check(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask
  task automatic wait_pulse(input logic [3:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (pulses == 4'h0 && n < 600);
    check("wake pulses", {4'h0, pulses}, {4'h0, exp});
  endtask
  task automatic give_verdict();
    $display("err_count %0d samples_checked %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock, time limit and tests
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    {reset_n, reg_wr, reg_rd, stack_full, low_volt_event} = 5'h00;
    {reg_addr, reg_wdata, irq_req, irq_enable} = 27'h000_0000;
    porta_pins = 8'hFF;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    check("status", {6'h00, status_flags}, 8'h00);
    reg_check(OFS_WDT_CTRL, WDT_CTRL_RESET);
    reg_check(OFS_RST_FLAGS, 8'h00);
    reg_check(3'h5, 8'h00);
    reg_write(OFS_WAKE_EN, 8'h01);
    for (int k = 0; k < 4; k++) begin
      reg_write(OFS_CLK_CTRL, 8'(k));
      wic_core_model_i.exec_halt();
      #1;
      check("halted", {7'h00, cpu_halted}, 8'h01);
      check("clocks", {6'h00, high_clk_on, sub_clk_on}, 8'(k));
      check("status", {6'h00, status_flags}, 8'h01);
      @(posedge clk_sys);
      porta_pins <= 8'hFD;
      repeat (2) @(posedge clk_sys);
      #1;
      check("masked pin", {7'h00, cpu_halted}, 8'h01);
      @(posedge clk_sys);
      porta_pins <= 8'hFC;
      wait_pulse(4'h1);
      @(posedge clk_sys);
      porta_pins <= 8'hFF;
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      irq_req <= 8'h02;
      irq_enable <= (i == 0) ? 8'h00 : 8'h08;
      stack_full <= (i == 1);
      wic_core_model_i.exec_halt();
      repeat (3) @(posedge clk_sys);
      #1;
      check("pending irq", {7'h00, cpu_halted}, 8'h01);
      @(posedge clk_sys);
      irq_req <= 8'h0A;
      wait_pulse((i == 2) ? 4'h2 : 4'h1);
    end
    @(posedge clk_sys);
    irq_req <= 8'h00;
    stack_full <= 1'b0;
    reg_check(OFS_STATUS, 8'h01);
    reg_write(OFS_STATUS, 8'h00);
    reg_check(OFS_STATUS, 8'h01);
    wic_core_model_i.exec_clear();
    reg_check(OFS_STATUS, 8'h00);
    reg_write(OFS_WDT_CTRL, 8'hAB);
    reg_check(OFS_WDT_CTRL, 8'hAB);
    reg_write(OFS_WDT_CTRL, 8'h57);
    reg_check(OFS_WDT_CTRL, 8'h57);
    reg_write(OFS_WDT_CTRL, 8'h03);
    wait_pulse(4'h8);
    reg_check(OFS_RST_FLAGS, 8'h01);
    reg_check(OFS_WDT_CTRL, WDT_CTRL_RESET);
    reg_write(OFS_RST_FLAGS, 8'h00);
    reg_check(OFS_RST_FLAGS, 8'h00);
    @(posedge clk_sys);
    low_volt_event <= 1'b1;
    @(posedge clk_sys);
    low_volt_event <= 1'b0;
    reg_check(OFS_RST_FLAGS, 8'h04);
    // Shortest period: overflow while halted, then while running
    reg_write(OFS_WDT_CTRL, 8'h50);
    wic_core_model_i.exec_halt();
    wait_pulse(4'h4);
    check("status", {6'h00, status_flags}, 8'h03);
    check("halted", {7'h00, cpu_halted}, 8'h00);
    wait_pulse(4'h8);
    check("status", {6'h00, status_flags}, 8'h03);
    reg_check(OFS_WDT_CTRL, WDT_CTRL_RESET);
    give_verdict();
  end
endmodule
